//--- logic/spc_pkg.sv
// Constants for the system PLL control block: register map, fields, resets, timing.
// Assumes a 125 MHz system clock and a 16-bit register port.
`default_nettype none
package spc_pkg;
	localparam int ADDR_W = 32;
	localparam int DATA_W = 16;

	// Register addresses
	localparam logic [31:0] ADDR_CTRL_ONE = 32'h5000_3310;
	localparam logic [31:0] ADDR_CTRL_TWO = 32'h5000_3312;
	localparam logic [31:0] ADDR_CTRL_THREE = 32'h5000_3314;
	localparam logic [31:0] ADDR_STATUS = 32'h5000_3316;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'h5000_3318;
	localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h5000_331A;
	localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h5000_331C;

	// Control one fields
	localparam int PLL_EN_BIT = 0;
	localparam int REG_ON_BIT = 1;
	localparam int REF_HOLD_BIT = 2;
	localparam int OUT_DIV_LSB = 8;
	localparam int DIV_W = 7;

	// Control two fields
	localparam int LOOP_DIV_LSB = 0;
	localparam int PFD_DEL_LSB = 12;
	localparam int PFD_DEL_W = 2;
	localparam int AUTO_SEL_BIT = 14;

	// Control three fields
	localparam int ICP_LSB = 0;
	localparam int ICP_W = 5;
	localparam int START_DEL_LSB = 10;
	localparam int START_DEL_W = 5;
	localparam int RECAL_BIT = 15;

	// Status fields
	localparam int LOCK_BIT = 0;
	localparam int REG_OK_BIT = 1;
	localparam int BAND_LSB = 5;
	localparam int BAND_W = 6;
	localparam int CAL_DONE_BIT = 11;

	// Reset values
	localparam logic [6:0] OUT_DIV_RST = 7'h01;
	localparam logic [6:0] LOOP_DIV_RST = 7'h06;
	localparam logic [1:0] PFD_DEL_RST = 2'h2;
	localparam logic [4:0] START_DEL_RST = 5'h0F;
	localparam logic [4:0] ICP_RST = 5'h09;

	// Interrupt bits
	localparam int IRQ_W = 4;
	localparam int IRQ_LOCK_GAIN = 0;
	localparam int IRQ_LOCK_LOSS = 1;
	localparam int IRQ_CAL_DONE = 2;
	localparam int IRQ_REG_OK = 3;

	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int START_STEP_NS = 48;
	localparam int START_STEP_CYCLES_RAW = (START_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_STEP_CYCLES = (START_STEP_CYCLES_RAW < 1) ? 1 : START_STEP_CYCLES_RAW;
	localparam int PRE_CNT_W = 10;

	// Synchronised analog inputs: lock, regulator ok, band, calibration done
	localparam int SYNC_W = 9;
endpackage
`default_nettype wire

//--- logic/spc_precharge_timer.sv
// Loop filter precharge timer: holds precharge after PLL enable for a programmed time.
// Assumes enable and delay come from registers on the same clock.
`default_nettype none
module spc_precharge_timer
	import spc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic enable,
	input wire logic [START_DEL_W-1:0] delaySteps,
	output logic prechargeOn
);
	logic enableDly_reg;
	logic [PRE_CNT_W-1:0] count_reg;
	logic [PRE_CNT_W-1:0] loadValue;

	assign loadValue = PRE_CNT_W'(delaySteps * START_STEP_CYCLES);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			enableDly_reg <= 1'b0;
		end else begin
			enableDly_reg <= enable;
		end
	end

	// Delay taken at the enable edge; later writes act on the next enable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
		end else if (enable && !enableDly_reg) begin
			count_reg <= loadValue;
		end else if (!enable) begin
			count_reg <= '0;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - PRE_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prechargeOn <= 1'b0;
		end else begin
			prechargeOn <= enable && (!enableDly_reg || count_reg > PRE_CNT_W'(1));
		end
	end
endmodule
`default_nettype wire

//--- logic/spc_system_pll_control.sv
// System PLL control and status registers with analog-facing controls and interrupt.
// Assumes analog status inputs are asynchronous and a single-cycle register port.
//
// Our own choice: the strobed register port.
`default_nettype none
module spc_system_pll_control
	import spc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DATA_W-1:0] regRdData,
	output logic irq,
	output logic pllEnable,
	output logic synthRegulatorOn,
	output logic regulatorReferenceHold,
	output logic [DIV_W-1:0] outputDivider,
	output logic [DIV_W-1:0] loopDivider,
	output logic vcoCurrentAutoSelect,
	output logic [PFD_DEL_W-1:0] phaseDetectorDelay,
	output logic prechargeOn,
	output logic [ICP_W-1:0] chargePumpCurrent,
	output logic calibrationStart,
	input wire logic pllLockIn,
	input wire logic regulatorInRegulationIn,
	input wire logic calibrationDoneIn,
	input wire logic [BAND_W-1:0] calibratedVcoBandIn
);
	// Stored register fields
	logic [DIV_W-1:0] outDivField_reg;
	logic [DIV_W-1:0] loopDivField_reg;
	logic [START_DEL_W-1:0] startDelay_reg;
	logic recalBusy_reg;
	logic calibrationDone_reg;
	logic [BAND_W-1:0] calibratedVcoBand_reg;

	// Analog input synchroniser and edge history
	logic [SYNC_W-1:0] syncMeta_reg;
	logic [SYNC_W-1:0] syncOut_reg;
	logic lockDly_reg;
	logic regOkDly_reg;
	logic calDoneDly_reg;
	logic pllLock;
	logic regOk;
	logic calDoneLevel;
	logic [BAND_W-1:0] bandSync;

	// Interrupt registers
	logic [IRQ_W-1:0] irqStatus_reg;
	logic [IRQ_W-1:0] irqEnable_reg;
	logic [IRQ_W-1:0] irqEvent;
	logic [IRQ_W-1:0] irqClear;

	// Decoded strobes
	logic wrCtrlOne;
	logic wrCtrlTwo;
	logic wrCtrlThree;
	logic wrIrqEnable;
	logic wrIrqClear;
	logic recalRequest;
	logic calDoneRise;
	logic [DATA_W-1:0] readValue;

	assign wrCtrlOne = regWr && (regAddr == ADDR_CTRL_ONE);
	assign wrCtrlTwo = regWr && (regAddr == ADDR_CTRL_TWO);
	assign wrCtrlThree = regWr && (regAddr == ADDR_CTRL_THREE);
	assign wrIrqEnable = regWr && (regAddr == ADDR_IRQ_ENABLE);
	assign wrIrqClear = regWr && (regAddr == ADDR_IRQ_CLEAR);
	assign recalRequest = wrCtrlThree && regWrData[RECAL_BIT];

	// Control one
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pllEnable <= 1'b0;
			synthRegulatorOn <= 1'b0;
			regulatorReferenceHold <= 1'b0;
			outDivField_reg <= OUT_DIV_RST;
		end else if (wrCtrlOne) begin
			pllEnable <= regWrData[PLL_EN_BIT];
			synthRegulatorOn <= regWrData[REG_ON_BIT];
			regulatorReferenceHold <= regWrData[REF_HOLD_BIT];
			outDivField_reg <= regWrData[OUT_DIV_LSB +: DIV_W];
		end
	end

	// Control two
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			loopDivField_reg <= LOOP_DIV_RST;
			phaseDetectorDelay <= PFD_DEL_RST;
			vcoCurrentAutoSelect <= 1'b0;
		end else if (wrCtrlTwo) begin
			loopDivField_reg <= regWrData[LOOP_DIV_LSB +: DIV_W];
			phaseDetectorDelay <= regWrData[PFD_DEL_LSB +: PFD_DEL_W];
			vcoCurrentAutoSelect <= regWrData[AUTO_SEL_BIT];
		end
	end

	// Control three
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			startDelay_reg <= START_DEL_RST;
			chargePumpCurrent <= ICP_RST;
		end else if (wrCtrlThree) begin
			startDelay_reg <= regWrData[START_DEL_LSB +: START_DEL_W];
			chargePumpCurrent <= regWrData[ICP_LSB +: ICP_W];
		end
	end

	// Effective dividers: a zero field would stall the divider, so it runs as one
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			outputDivider <= OUT_DIV_RST;
			loopDivider <= LOOP_DIV_RST;
		end else begin
			outputDivider <= (outDivField_reg == '0) ? DIV_W'(1) : outDivField_reg;
			loopDivider <= (loopDivField_reg == '0) ? DIV_W'(1) : loopDivField_reg;
		end
	end

	spc_precharge_timer precharge (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.enable(pllEnable),
		.delaySteps(startDelay_reg),
		.prechargeOn(prechargeOn)
	);

	// Two-flop synchroniser on every analog status bit
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			syncMeta_reg <= '0;
			syncOut_reg <= '0;
		end else begin
			syncMeta_reg <= {calibrationDoneIn, calibratedVcoBandIn, regulatorInRegulationIn,
				pllLockIn};
			syncOut_reg <= syncMeta_reg;
		end
	end

	assign pllLock = syncOut_reg[0];
	assign regOk = syncOut_reg[1];
	assign bandSync = syncOut_reg[2 +: BAND_W];
	assign calDoneLevel = syncOut_reg[SYNC_W-1];

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lockDly_reg <= 1'b0;
			regOkDly_reg <= 1'b0;
			calDoneDly_reg <= 1'b0;
		end else begin
			lockDly_reg <= pllLock;
			regOkDly_reg <= regOk;
			calDoneDly_reg <= calDoneLevel;
		end
	end

	// Calibration counts as finished on every rising done edge, whether or not a request came first
	assign calDoneRise = calDoneLevel && !calDoneDly_reg;

	// Recalibration pulse to the analog calibrator
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			calibrationStart <= 1'b0;
		end else begin
			calibrationStart <= recalRequest;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			recalBusy_reg <= 1'b0;
		end else if (recalRequest) begin
			recalBusy_reg <= 1'b1;
		end else if (calDoneRise) begin
			recalBusy_reg <= 1'b0;
		end
	end

	// Done flag: the finishing edge wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			calibrationDone_reg <= 1'b0;
		end else if (calDoneRise) begin
			calibrationDone_reg <= 1'b1;
		end else if (recalRequest) begin
			calibrationDone_reg <= 1'b0;
		end
	end

	// Band is caught on the done edge, when the calibrator holds it stable
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			calibratedVcoBand_reg <= '0;
		end else if (calDoneRise) begin
			calibratedVcoBand_reg <= bandSync;
		end
	end

	// Interrupt events
	assign irqEvent[IRQ_LOCK_GAIN] = pllLock && !lockDly_reg;
	assign irqEvent[IRQ_LOCK_LOSS] = !pllLock && lockDly_reg;
	assign irqEvent[IRQ_CAL_DONE] = calDoneRise;
	assign irqEvent[IRQ_REG_OK] = regOk && !regOkDly_reg;
	assign irqClear = wrIrqClear ? regWrData[IRQ_W-1:0] : '0;

	// Sticky status, set wins over clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irqStatus_reg <= '0;
		end else begin
			irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvent;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irqEnable_reg <= '0;
		end else if (wrIrqEnable) begin
			irqEnable_reg <= regWrData[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irqStatus_reg & ~irqClear) | irqEvent) & irqEnable_reg);
		end
	end

	// Read mux; reserved bits and unmapped addresses read zero
	always_comb begin
		readValue = '0;
		unique case (regAddr)
			ADDR_CTRL_ONE: begin
				readValue[PLL_EN_BIT] = pllEnable;
				readValue[REG_ON_BIT] = synthRegulatorOn;
				readValue[REF_HOLD_BIT] = regulatorReferenceHold;
				readValue[OUT_DIV_LSB +: DIV_W] = outDivField_reg;
			end
			ADDR_CTRL_TWO: begin
				readValue[LOOP_DIV_LSB +: DIV_W] = loopDivField_reg;
				readValue[PFD_DEL_LSB +: PFD_DEL_W] = phaseDetectorDelay;
				readValue[AUTO_SEL_BIT] = vcoCurrentAutoSelect;
			end
			ADDR_CTRL_THREE: begin
				readValue[ICP_LSB +: ICP_W] = chargePumpCurrent;
				readValue[START_DEL_LSB +: START_DEL_W] = startDelay_reg;
				readValue[RECAL_BIT] = recalBusy_reg;
			end
			ADDR_STATUS: begin
				readValue[LOCK_BIT] = pllLock;
				readValue[REG_OK_BIT] = regOk;
				readValue[BAND_LSB +: BAND_W] = calibratedVcoBand_reg;
				readValue[CAL_DONE_BIT] = calibrationDone_reg;
			end
			ADDR_IRQ_STATUS: begin
				readValue[IRQ_W-1:0] = irqStatus_reg;
			end
			ADDR_IRQ_ENABLE: begin
				readValue[IRQ_W-1:0] = irqEnable_reg;
			end
			default: begin
				readValue = '0;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			regRdData <= '0;
		end else if (regRd) begin
			regRdData <= readValue;
		end else begin
			regRdData <= '0;
		end
	end
endmodule
`default_nettype wire

//--- testbench/spc_system_pll_control_chk.sv
// Port checker for the system PLL control block.
// Assumes one clock domain and at least one idle cycle between writes.
`default_nettype none
module spc_system_pll_control_chk
	import spc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [DATA_W-1:0] regRdData,
	input wire logic pllEnable,
	input wire logic synthRegulatorOn,
	input wire logic [DIV_W-1:0] outputDivider,
	input wire logic [DIV_W-1:0] loopDivider,
	input wire logic vcoCurrentAutoSelect,
	input wire logic [PFD_DEL_W-1:0] phaseDetectorDelay,
	input wire logic prechargeOn,
	input wire logic [ICP_W-1:0] chargePumpCurrent,
	input wire logic calibrationStart
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	function automatic logic [6:0] effDiv(input logic [6:0] f);
		return (f == 7'h00) ? 7'h01 : f;
	endfunction
	sequence s_wr_one;
		regWr && regAddr == ADDR_CTRL_ONE;
	endsequence
	sequence s_wr_two;
		regWr && regAddr == ADDR_CTRL_TWO;
	endsequence
	sequence s_wr_three;
		regWr && regAddr == ADDR_CTRL_THREE;
	endsequence
	// Read data must not linger, or a stale word could pass for a fresh read
	a_read_idle: assert property (!$past(regRd) |-> regRdData == 16'h0000)
		else $error("read data outside its cycle");
	a_pll_enable: assert property (s_wr_one |=> pllEnable == $past(regWrData[0]))
		else $error("pll enable not taken from write");
	a_regulator_on: assert property (s_wr_one |=> synthRegulatorOn == $past(regWrData[1]))
		else $error("regulator enable not taken from write");
	// Dividers may lag one extra cycle, so they are judged two edges on
	a_out_div: assert property (s_wr_one ##2 1'b1 |->
		outputDivider == effDiv($past(regWrData[14:8], 2))) else $error("output divider wrong");
	a_loop_div: assert property (s_wr_two ##2 1'b1 |->
		loopDivider == effDiv($past(regWrData[6:0], 2))) else $error("loop divider wrong");
	a_pfd_delay: assert property (s_wr_two |=> phaseDetectorDelay == $past(regWrData[13:12]))
		else $error("phase detector delay wrong");
	a_auto_select: assert property (s_wr_two |=> vcoCurrentAutoSelect == $past(regWrData[14]))
		else $error("vco current source wrong");
	a_pump_current: assert property (s_wr_three |=> chargePumpCurrent == $past(regWrData[4:0]))
		else $error("charge pump current wrong");
	a_recal_pulse: assert property (1'b1 |-> calibrationStart ==
		$past(regWr && regAddr == ADDR_CTRL_THREE && regWrData[15])) else $error("recal pulse wrong");
	a_precharge_go: assert property ($rose(pllEnable) |=> prechargeOn)
		else $error("precharge not started");
endmodule
bind spc_system_pll_control spc_system_pll_control_chk u_chk (.clk_sys, .nrst, .regAddr,
	.regWrData, .regWr, .regRd, .regRdData, .pllEnable, .synthRegulatorOn, .outputDivider,
	.loopDivider, .vcoCurrentAutoSelect, .phaseDetectorDelay, .prechargeOn, .chargePumpCurrent,
	.calibrationStart);
`default_nettype wire

//--- testbench/test_spc_system_pll_control.sv
// Self-checking bench for the system PLL control block.
// Assumes reads answer in the next cycle only and analog inputs settle in six cycles.
`default_nettype none
module test_spc_system_pll_control
	import spc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, nrst, regWr, regRd, irq, pllEnable, synthRegulatorOn, regulatorReferenceHold;
	logic vcoCurrentAutoSelect, prechargeOn, calibrationStart;
	logic pllLockIn, regulatorInRegulationIn, calibrationDoneIn;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] regWrData, regRdData;
	logic [DIV_W-1:0] outputDivider, loopDivider;
	logic [PFD_DEL_W-1:0] phaseDetectorDelay;
	logic [ICP_W-1:0] chargePumpCurrent;
	logic [BAND_W-1:0] calibratedVcoBandIn;
	int nMismatch = 0;
	int cmpCount = 0;
	int cycles = 0;
	spc_system_pll_control u_dut (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
		.pllEnable(pllEnable), .synthRegulatorOn(synthRegulatorOn),
		.regulatorReferenceHold(regulatorReferenceHold), .outputDivider(outputDivider),
		.loopDivider(loopDivider), .vcoCurrentAutoSelect(vcoCurrentAutoSelect),
		.phaseDetectorDelay(phaseDetectorDelay), .prechargeOn(prechargeOn),
		.chargePumpCurrent(chargePumpCurrent), .calibrationStart(calibrationStart),
		.pllLockIn(pllLockIn), .regulatorInRegulationIn(regulatorInRegulationIn),
		.calibrationDoneIn(calibrationDoneIn), .calibratedVcoBandIn(calibratedVcoBandIn));
	task automatic report_and_stop;
		if (nMismatch == 0 && cmpCount > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmpCount++;
		if (got !== exp) begin
			nMismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	// Data is sampled just after the edge that took the strobe, its only valid cycle
	task automatic rd(input logic [31:0] a, input logic [15:0] exp, input string what);
		@(posedge clk_sys);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk(what, exp, regRdData);
	endtask
	task automatic t_reset;
		chk("outDiv", 16'h0001, {9'h0, outputDivider});
		chk("loopDiv", 16'h0006, {9'h0, loopDivider});
		chk("pfd", 16'h0002, {14'h0, phaseDetectorDelay});
		chk("icp", 16'h0009, {11'h0, chargePumpCurrent});
		rd(ADDR_CTRL_ONE, 16'h0100, "ctrl1");
		rd(ADDR_CTRL_TWO, 16'h2006, "ctrl2");
		rd(ADDR_CTRL_THREE, 16'h3C09, "ctrl3");
		rd(ADDR_STATUS, 16'h0000, "status");
	endtask
	task automatic t_fields;
		wr(ADDR_CTRL_ONE, 16'hFFFF);
		rd(ADDR_CTRL_ONE, 16'h7F07, "ctrl1");
		chk("pins1", 16'h7F07, {1'b0, outputDivider, 5'h0, regulatorReferenceHold,
			synthRegulatorOn, pllEnable});
		wr(ADDR_CTRL_ONE, 16'h0000);
		rd(ADDR_CTRL_ONE, 16'h0000, "ctrl1");
		chk("pins1", 16'h0100, {1'b0, outputDivider, 8'h0});
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CTRL_TWO, {2'b11, 2'(c), 12'hF80});
			rd(ADDR_CTRL_TWO, {2'b01, 2'(c), 12'h000}, "ctrl2");
			chk("pins2", {6'h0, 1'b1, 2'(c), 7'h01}, {6'h0, vcoCurrentAutoSelect,
				phaseDetectorDelay, loopDivider});
		end
		wr(ADDR_CTRL_TWO, 16'h0045);
		rd(ADDR_CTRL_TWO, 16'h0045, "ctrl2");
		chk("pins2", 16'h0045, {6'h0, vcoCurrentAutoSelect, phaseDetectorDelay, loopDivider});
		wr(ADDR_CTRL_THREE, 16'h7FFF);
		rd(ADDR_CTRL_THREE, 16'h7C1F, "ctrl3");
		chk("icp", 16'h001F, {11'h0, chargePumpCurrent});
		wr(ADDR_STATUS, 16'hFFFF);
		rd(ADDR_STATUS, 16'h0000, "status");
		rd(32'h5000_3320, 16'h0000, "unmapped");
	endtask
	task automatic t_precharge;
		int n;
		for (int i = 0; i < 2; i++) begin
			n = 0;
			wr(ADDR_CTRL_THREE, {1'b0, 5'(2 * i), 10'h009});
			wr(ADDR_CTRL_ONE, 16'h0001);
			repeat (40) begin
				@(posedge clk_sys);
				#1;
				if (prechargeOn === 1'b1) n++;
			end
			chk("preLen", 16'(i == 0 ? 1 : 2 * START_STEP_CYCLES), 16'(n));
			wr(ADDR_CTRL_ONE, 16'h0000);
		end
	endtask
	task automatic t_calib;
		@(posedge clk_sys);
		pllLockIn <= 1'b1;
		regulatorInRegulationIn <= 1'b1;
		calibratedVcoBandIn <= 6'h2A;
		calibrationDoneIn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(ADDR_STATUS, 16'h0D43, "status");
		wr(ADDR_CTRL_THREE, 16'hBC09);
		rd(ADDR_CTRL_THREE, 16'hBC09, "ctrl3");
		rd(ADDR_STATUS, 16'h0543, "status");
		@(posedge clk_sys);
		calibrationDoneIn <= 1'b0;
		calibratedVcoBandIn <= 6'h15;
		repeat (4) @(posedge clk_sys);
		calibrationDoneIn <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(ADDR_STATUS, 16'h0AA3, "status");
		rd(ADDR_CTRL_THREE, 16'h3C09, "ctrl3");
	endtask
	task automatic t_irq;
		wr(ADDR_IRQ_ENABLE, 16'h0000);
		rd(ADDR_IRQ_STATUS, 16'h000D, "irqSt");
		chk("irq", 16'h0000, {15'h0, irq});
		wr(ADDR_IRQ_ENABLE, 16'h0001);
		rd(ADDR_IRQ_ENABLE, 16'h0001, "irqEn");
		chk("irq", 16'h0001, {15'h0, irq});
		wr(ADDR_IRQ_CLEAR, 16'h0001);
		rd(ADDR_IRQ_STATUS, 16'h000C, "irqSt");
		chk("irq", 16'h0000, {15'h0, irq});
		@(posedge clk_sys);
		pllLockIn <= 1'b0;
		repeat (6) @(posedge clk_sys);
		wr(ADDR_IRQ_ENABLE, 16'h0002);
		rd(ADDR_IRQ_STATUS, 16'h000E, "irqSt");
		chk("irq", 16'h0001, {15'h0, irq});
		wr(ADDR_IRQ_CLEAR, 16'h000F);
		rd(ADDR_IRQ_STATUS, 16'h0000, "irqSt");
		chk("irq", 16'h0000, {15'h0, irq});
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Whole run needs under two thousand cycles, so this only trips on a hang
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			nMismatch++;
			report_and_stop();
		end
	end
	initial begin
		nrst = 1'b0;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 32'h0000_0000;
		regWrData = 16'h0000;
		pllLockIn = 1'b0;
		regulatorInRegulationIn = 1'b0;
		calibrationDoneIn = 1'b0;
		calibratedVcoBandIn = 6'h00;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_fields();
		t_precharge();
		t_calib();
		t_irq();
		report_and_stop();
	end
endmodule
`default_nettype wire
